/* File: core/osw_pkg.sv */
// shared constants and types for the internal oscillator frequency switch
package osw_pkg;
  // clock of the register side
  localparam int CLK_PERIOD_NS = 100;
  // settling delay after leaving the slow source, in microseconds
  localparam int SETTLE_TIME_US = 4000;
  localparam int SETTLE_CYCLES = SETTLE_TIME_US * 1000 / CLK_PERIOD_NS;
  // falling edges of the requested clock before handover
  localparam logic [2:0] HANDOVER_LAST = 3'h7;
  // postscaler depth: 8 MHz / 2 .. 8 MHz / 64
  localparam int DIV_W = 6;

  // register map: index as printed, byte address four times it
  localparam logic [11:0] OSC_CTRL_IDX = 12'h08f;
  localparam logic [11:0] OSC_CTRL_ADDR = 12'(OSC_CTRL_IDX * 4);
  localparam logic [11:0] IRQ_STATUS_ADDR = 12'h240;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h244;

  // control register fields and reset values
  localparam int SEL_LSB = 4;
  localparam int STABLE_BIT = 2;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [2:0] SEL_SLOW = 3'h0;
  localparam logic [2:0] SEL_FAST = 3'h7;

  // interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_STABLE_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_RUN, ST_PARK, ST_COUNT} osw_state_t;

  // observable switcher state
  typedef struct packed {
    logic [2:0] active_sel;
    logic       switching;
    logic       settling;
  } osw_stat_t;
endpackage

/* File: core/osw_top.sv */
// internal oscillator frequency select with glitch-free clock handover
`timescale 1ns/1ps
module osw_top
  import osw_pkg::*;
#(
  parameter int SETTLE = osw_pkg::SETTLE_CYCLES // settling delay in aclk cycles
) (
  input  wire logic              aclk,                 // 10 MHz clock
  input  wire logic              aresetn,              // synchronous reset, low
  input  wire logic [11:0]       s_axi_awaddr,         // write address
  input  wire logic              s_axi_awvalid,        // write address valid
  output logic                   s_axi_awready,        // write address ready
  input  wire logic [31:0]       s_axi_wdata,          // write data
  input  wire logic [3:0]        s_axi_wstrb,          // write byte enables
  input  wire logic              s_axi_wvalid,         // write data valid
  output logic                   s_axi_wready,         // write data ready
  output logic [1:0]             s_axi_bresp,          // write response
  output logic                   s_axi_bvalid,         // write response valid
  input  wire logic              s_axi_bready,         // write response ready
  input  wire logic [11:0]       s_axi_araddr,         // read address
  input  wire logic              s_axi_arvalid,        // read address valid
  output logic                   s_axi_arready,        // read address ready
  output logic [31:0]            s_axi_rdata,          // read data
  output logic [1:0]             s_axi_rresp,          // read response
  output logic                   s_axi_rvalid,         // read data valid
  input  wire logic              s_axi_rready,         // read data ready
  input  wire logic              fast_internal_source, // 8 MHz source level
  input  wire logic              slow_internal_source, // 31.25 kHz source level
  output logic                   switched_clock_out,   // glitch-free system clock
  output logic                   freq_stable_flag,     // fast source settled
  output osw_pkg::osw_stat_t     clk_status,           // switcher state
  output logic                   irq                   // level interrupt
);
  import osw_pkg::*;

  localparam int SW = $clog2(SETTLE + 1);

  if (SETTLE < 2 || SETTLE > 1000000) begin : g_chk
    $error("SETTLE out of range");
  end

  osw_state_t       st;
  logic [2:0]       sel;
  logic [2:0]       active;
  logic [2:0]       edge_cnt;
  logic [DIV_W-1:0] div;
  logic             fast_q;
  logic             slow_q;
  logic [DIV_W-1:0] div_q;
  logic             settling;
  logic [SW-1:0]    settle_cnt;
  logic [1:0]       irq_status;
  logic [1:0]       irq_mask;
  logic             aw_hold;
  logic             w_hold;
  logic [11:0]      aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             wr_go;
  logic             sel_chg;
  logic             cur_now;
  logic             cur_fall;
  logic             new_fall;
  logic             hand_done;
  logic             fast_fall;
  logic             stable_set;

  // level of the source picked by a select code
  function automatic logic src_lvl(input logic [2:0] s, input logic f,
                                   input logic sl, input logic [DIV_W-1:0] d);
    if (s == SEL_FAST) return f;
    if (s == SEL_SLOW) return sl;
    return d[3'(6) - s];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // postscaler: each stage halves the 8 MHz source
  assign fast_fall = fast_q && !fast_internal_source;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= '0;
    end else if (fast_fall) begin
      div <= div + DIV_W'(1);
    end
  end

  // previous source levels for falling edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_q <= 1'b0;
      slow_q <= 1'b0;
      div_q  <= '0;
    end else begin
      fast_q <= fast_internal_source;
      slow_q <= slow_internal_source;
      div_q  <= div;
    end
  end

  assign cur_now  = src_lvl(active, fast_internal_source, slow_internal_source, div);
  assign cur_fall = src_lvl(active, fast_q, slow_q, div_q) && !cur_now;
  assign new_fall = src_lvl(sel, fast_q, slow_q, div_q)
                    && !src_lvl(sel, fast_internal_source, slow_internal_source, div);

  ////////////////////////////////////////////////////////////////////
  // switch sequencer: park low on the old clock, count eight new edges
  // a write of a new select in the same cycle restarts the count instead of handing over
  assign hand_done = (st == ST_COUNT) && new_fall && (edge_cnt == HANDOVER_LAST) && !sel_chg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st       <= ST_RUN;
      active   <= SEL_RESET;
      edge_cnt <= '0;
    end else begin
      unique case (st)
        ST_RUN: begin
          if (sel != active) begin
            st <= ST_PARK;
          end
        end
        ST_PARK: begin
          edge_cnt <= '0;
          if (cur_fall) begin
            st <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          // a new select mid-count restarts the count on the new clock
          if (sel_chg) begin
            edge_cnt <= '0;
          end else if (hand_done) begin
            st     <= ST_RUN;
            active <= sel;
          end else if (new_fall) begin
            edge_cnt <= edge_cnt + 3'h1;
          end
        end
      endcase
    end
  end

  // output flop: follows the active source while running; while parked it may
  // only fall, so a high phase of the old clock is never cut into a runt pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      switched_clock_out <= 1'b0;
    end else begin
      switched_clock_out <= (st == ST_RUN) ? cur_now
                            : (st == ST_PARK) && switched_clock_out && cur_now;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // stable flag and settling delay
  // a fast-to-fast switch during settling leaves the flag to the timer,
  // the source itself has not settled yet
  assign stable_set = settling && (settle_cnt == SW'(1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_stable_flag <= 1'b0;
      settling         <= 1'b0;
      settle_cnt       <= '0;
    end else if (hand_done && active == SEL_SLOW) begin
      freq_stable_flag <= 1'b0;
      settling         <= 1'b1;
      settle_cnt       <= SW'(SETTLE);
    end else if (hand_done && sel == SEL_SLOW) begin
      settling         <= 1'b0;
    end else if (hand_done && !settling) begin
      freq_stable_flag <= 1'b1;
    end else if (stable_set) begin
      freq_stable_flag <= 1'b1;
      settling         <= 1'b0;
    end else if (settling) begin
      settle_cnt <= settle_cnt - SW'(1);
    end
  end

  assign clk_status = '{active_sel: active, switching: st != ST_RUN, settling: settling};

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign wr_go         = aw_hold && w_hold;
  assign sel_chg       = wr_go && aw_addr == OSC_CTRL_ADDR && w_strb[0]
                         && w_data[SEL_LSB +: 3] != sel;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == OSC_CTRL_ADDR || aw_addr == IRQ_STATUS_ADDR
                         || aw_addr == IRQ_MASK_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // registers written by software; select taken in any clock state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel      <= SEL_RESET;
      irq_mask <= IRQ_RESET;
    end else if (wr_go && w_strb[0]) begin
      if (aw_addr == OSC_CTRL_ADDR) begin
        sel <= w_data[SEL_LSB +: 3];
      end
      if (aw_addr == IRQ_MASK_ADDR) begin
        irq_mask <= w_data[1:0];
      end
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~((wr_go && w_strb[0] && aw_addr == IRQ_STATUS_ADDR)
                                    ? w_data[1:0] : 2'h0))
                    | {stable_set || (hand_done && sel != SEL_SLOW && active != SEL_SLOW
                                      && !settling), hand_done};
    end
  end
  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path: one read in flight, data from a flop
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        OSC_CTRL_ADDR:   s_axi_rdata <= {24'h0, 1'b0, sel, 1'b0, freq_stable_flag, 2'h0};
        IRQ_STATUS_ADDR: s_axi_rdata <= {30'h0, irq_status};
        IRQ_MASK_ADDR:   s_axi_rdata <= {30'h0, irq_mask};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RUN_FOLLOWS: assert property (st == ST_RUN ##1 st == ST_RUN |->
    switched_clock_out == $past(cur_now)) else $error("output not following source");
  AST_PARK_ON_CHANGE: assert property (st == ST_RUN && sel != active |=> st == ST_PARK)
    else $error("select change did not park");
  AST_HELD_LOW: assert property (st == ST_COUNT |=> !switched_clock_out)
    else $error("output not low while counting");
  AST_NO_RISE: assert property (st != ST_RUN |=> !$rose(switched_clock_out))
    else $error("output rose during a switch");
  AST_EIGHT_EDGES: assert property (hand_done |-> edge_cnt == 3'h7
    ##1 st == ST_RUN && active == $past(sel)) else $error("handover count wrong");
  AST_SETTLE_START: assert property (hand_done && active == SEL_SLOW |=>
    !freq_stable_flag && settling && settle_cnt == SW'(SETTLE)) else $error("settle not begun");
  AST_SETTLE_END: assert property (stable_set |=> freq_stable_flag && !settling)
    else $error("stable not set at delay end");
  AST_FAST_STABLE: assert property (hand_done && active != SEL_SLOW && sel != SEL_SLOW
    && !settling |=> freq_stable_flag) else $error("fast switch left flag clear");
  AST_SLOW_DIRECT: assert property (hand_done && sel == SEL_SLOW |=> !settling
    && st == ST_RUN) else $error("slow switch started a delay");
  AST_NO_SPURIOUS: assert property (st == ST_RUN && sel == active && !settling |=>
    st == ST_RUN && $stable(freq_stable_flag)) else $error("idle write disturbed switch");
  AST_RESERVED_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == '0
    && s_axi_rdata[3] == 1'b0) else $error("reserved bits not zero");

  COV_SLOW_TO_FAST: cover property (hand_done && active == SEL_SLOW);
  COV_FAST_TO_FAST: cover property (hand_done && active != SEL_SLOW && sel != SEL_SLOW);
  COV_FAST_TO_SLOW: cover property (hand_done && sel == SEL_SLOW);
  COV_STABLE: cover property (stable_set);
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the oscillator frequency switch
`timescale 1ns/1ps
module tb_top;
  import osw_pkg::*;
  localparam int SETTLE = 20; // short settle keeps the run brief
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [11:0]       awaddr = 12'h000;
  logic              awvalid = 1'b0;
  logic [31:0]       wdata = 32'h0;
  logic              wvalid = 1'b0;
  logic [11:0]       araddr = 12'h000;
  logic              arvalid = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, r;
  logic [31:0]       rdata, d;
  logic [3:0]        src_cnt = 4'h0;
  logic              clk_out, out_q, flag, irq, sw_q;
  osw_stat_t         stat;
  logic [2:0]        cur, s;
  int                n, sc, error_cnt, cmp_count;

  ////////////////////////////////////////////////////////////////////////////
  // clock; sources run slower than aclk/2 so every edge is sampled
  always #50 aclk = ~aclk;
  always @(posedge aclk) src_cnt <= src_cnt + 4'h1;
  always @(posedge aclk) out_q <= clk_out;
  // settling cycles since the last switch ended
  always @(posedge aclk) sc <= stat.switching ? 0 : sc + int'(stat.settling);

  osw_top #(.SETTLE(SETTLE)) osw_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .fast_internal_source(src_cnt[1]), .slow_internal_source(src_cnt[3]),
    .switched_clock_out(clk_out), .freq_stable_flag(flag), .clk_status(stat), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // output may fall but never rise while a switch is under way
  always @(negedge aclk) begin
    sw_q <= stat.switching;
    if (aresetn && sw_q && stat.switching) check("no_rise", clk_out && !out_q, 1'b0);
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic give_up();
    error_cnt++;
    stop_test();
  endtask

  // bready and rready stay high, so the answer is taken where it is seen
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && k < 50);
    if (k >= 50) give_up();
    rs = bresp;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && k < 50);
    if (k >= 50) give_up();
    v = rdata;
    rs = rresp;
  endtask

  // fast source period is 4 aclk, slow is 16; each postscaler step halves
  function automatic int exp_period(input logic [2:0] sel);
    return (sel == SEL_SLOW) ? 16 : 4 << (7 - int'(sel));
  endfunction

  task automatic wait_switch(output int dur);
    int k;
    k = 0;
    while (!stat.switching && k < 20) begin
      @(posedge aclk);
      k++;
    end
    dur = 0;
    while (stat.switching && dur < 4000) begin
      @(posedge aclk);
      dur++;
    end
    if (k >= 20 || dur >= 4000) give_up();
  endtask

  task automatic measure_period(output int p);
    int k;
    k = 0;
    while (!(clk_out && !out_q) && k < 600) begin
      @(posedge aclk);
      k++;
    end
    p = 0;
    do begin
      @(posedge aclk);
      p++;
    end while (!(clk_out && !out_q) && p < 600);
  endtask

  // bit 7 and bits 3:0 are written as ones on every switch made by this task
  task automatic do_switch(input logic [2:0] sel, input int slack);
    int dur, p, po;
    po = exp_period(cur);
    axi_write(OSC_CTRL_ADDR, {24'h0, 1'b1, sel, 4'hf}, r);
    wait_switch(dur);
    check("switch_len", dur >= 7 * exp_period(sel) && dur <= po + 8 * exp_period(sel) + slack, 1);
    check("active_sel", stat.active_sel, sel);
    measure_period(p);
    check("period", p, exp_period(sel));
    cur = sel;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(50285));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cur = SEL_SLOW;
    axi_read(OSC_CTRL_ADDR, d, r);
    check("ctrl_reset", d, 32'h0);
    check("flag_reset", flag, 1'b0);
    axi_read(IRQ_MASK_ADDR, d, r);
    check("mask_reset", d, 32'h0);
    axi_write(IRQ_MASK_ADDR, 32'h2, r);
    do_switch(SEL_FAST, 12);
    check("flag_settling", flag, 1'b0);
    axi_read(OSC_CTRL_ADDR, d, r);
    check("ctrl_sel", d, 32'h70);
    check("irq_masked", irq, 1'b0);
    n = 0;
    while (!flag && n < 100) begin
      @(posedge aclk);
      n++;
    end
    check("settle_len", sc >= SETTLE - 3 && sc <= SETTLE + 3 && flag, 1);
    check("irq_set", irq, 1'b1);
    axi_read(IRQ_STATUS_ADDR, d, r);
    check("irq_status", d, 32'h3);
    axi_write(IRQ_STATUS_ADDR, 32'h3, r);
    axi_read(IRQ_STATUS_ADDR, d, r);
    check("irq_clear", {d[1:0], irq}, 3'h0);
    // same select with read-only bits set: nothing may move
    axi_write(OSC_CTRL_ADDR, 32'h7c, r);
    repeat (10) @(posedge aclk);
    check("no_switch", {stat.switching, flag}, 2'h1);
    axi_read(OSC_CTRL_ADDR, d, r);
    check("ctrl_stable", d, 32'h74);
    for (int c = 6; c >= 1; c--) begin
      do_switch(3'(c), 12);
      check("flag_fast", flag, 1'b1);
      axi_read(IRQ_STATUS_ADDR, d, r);
      check("irq_fast", d, 32'h3);
      axi_write(IRQ_STATUS_ADDR, 32'h3, r);
    end
    repeat (3) begin
      s = 3'($urandom_range(1, 7));
      if (s == cur) s = (s == 3'h7) ? 3'h1 : s + 3'h1;
      do_switch(s, 12);
      check("flag_rand", flag, 1'b1);
    end
    // a new select in mid-handover restarts on the newest one
    axi_write(OSC_CTRL_ADDR, {25'h0, (cur == 3'h6) ? 3'h5 : 3'h6, 4'h0}, r);
    repeat (3) @(posedge aclk);
    do_switch(3'h3, 300);
    do_switch(SEL_SLOW, 12);
    check("flag_to_slow", {flag, stat.settling}, 2'h2);
    axi_read(12'h100, d, r);
    check("unmapped_read", d, 32'h0);
    check("unmapped_rresp", r, RESP_SLVERR);
    axi_write(12'h100, 32'hff, r);
    check("unmapped_write", r, RESP_SLVERR);
    stop_test();
  end
endmodule
